// file: core/qbp_consts.svh
/*
  Constants for the quasi-bidirectional port: reset values, alternate pin
  positions and strong-driver timing. Assumes inclusion by its bare name.
*/
`ifndef QBP_CONSTS_SVH
`define QBP_CONSTS_SVH

`define QBP_WIDTH 8
`define QBP_LATCH_RST 8'hFF
`define QBP_SYNC_RST 1'b1
`define QBP_CLK_MHZ 10
`define QBP_STRONG_NS 200
`define QBP_STRONG_CYC ((`QBP_STRONG_NS * `QBP_CLK_MHZ + 999) / 1000)
`define QBP_BIT_T2_IO 0
`define QBP_BIT_T2_TRIG 1
`define QBP_BIT_SER_RX 2
`define QBP_BIT_SER_TX 3
`define QBP_BIT_IRQ_RA 4
`define QBP_BIT_IRQ_FA 5
`define QBP_BIT_IRQ_RB 6
`define QBP_BIT_IRQ_FB 7

`endif

// file: core/qbp_pkg.sv
/*
  Types for the quasi-bidirectional port. Assumes qbp_consts.svh is on the
  include path.
*/
`include "qbp_consts.svh"

package qbp_pkg;

  typedef logic [`QBP_WIDTH-1:0] qbp_byte_t;
  typedef logic [1:0] qbp_cnt_t;

  // Drive controls for all pins, strong enables active low, weak pullup active high
  typedef struct packed {
    qbp_byte_t pd_oe_n;
    qbp_byte_t ph_oe_n;
    qbp_byte_t pu_weak;
  } qbp_drive_s;

  // Alternate inputs seen by on-chip peripherals
  typedef struct packed {
    logic timer_two_ext_io;
    logic timer_two_capture_trigger;
    logic second_serial_receive;
  } qbp_alt_in_s;

  // Alternate outputs driven by on-chip peripherals, with their enables
  typedef struct packed {
    logic timer_two_ext_io_en;
    logic timer_two_ext_io;
    logic second_serial_transmit_en;
    logic second_serial_transmit;
  } qbp_alt_out_s;

  // Edge-detect interrupt requests
  typedef struct packed {
    logic ext_irq_rise_a;
    logic ext_irq_fall_a;
    logic ext_irq_rise_b;
    logic ext_irq_fall_b;
  } qbp_irq_s;

  typedef struct packed {
    qbp_byte_t s1;
    qbp_byte_t s2;
    qbp_byte_t s3;
    qbp_byte_t level;
  } qbp_sync_s;

  typedef struct packed {
    qbp_byte_t prev;
    qbp_byte_t rise;
    qbp_byte_t fall;
  } qbp_edge_s;

endpackage

// file: core/qbp_pin_sync.sv
/*
  Three-stage synchroniser for the pin levels; a new level is accepted once
  the second and third stages agree. Assumes pins are asynchronous.
*/
`timescale 1ns/1ps
`include "qbp_consts.svh"

module qbp_pin_sync (
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  input wire qbp_pkg::qbp_byte_t pin_i,
  output qbp_pkg::qbp_byte_t level_o
);
  import qbp_pkg::*;

  qbp_sync_s st_ff;
  qbp_sync_s nxt_st;

  always_comb begin
    nxt_st = st_ff;
    nxt_st.s1 = pin_i;
    nxt_st.s2 = st_ff.s1;
    nxt_st.s3 = st_ff.s2;
    for (int i = 0; i < `QBP_WIDTH; i++) begin
      if (st_ff.s2[i] == st_ff.s3[i]) begin
        nxt_st.level[i] = st_ff.s3[i];
      end
    end
  end

  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      st_ff <= {4{`QBP_LATCH_RST}};
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign level_o = st_ff.level;
endmodule

// file: core/qbp_edge_det.sv
/*
  Registered rise and fall detectors on synchronised pin levels, each gated
  per pin. Assumes levels already in the system clock domain.
*/
`timescale 1ns/1ps
`include "qbp_consts.svh"

module qbp_edge_det (
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  input wire qbp_pkg::qbp_byte_t level_i,
  input wire qbp_pkg::qbp_byte_t gate_i,
  output qbp_pkg::qbp_byte_t rise_o,
  output qbp_pkg::qbp_byte_t fall_o
);
  import qbp_pkg::*;

  qbp_edge_s st_ff;
  qbp_edge_s nxt_st;

  always_comb begin
    nxt_st = st_ff;
    nxt_st.prev = level_i;
    nxt_st.rise = level_i & ~st_ff.prev & gate_i;
    nxt_st.fall = ~level_i & st_ff.prev & gate_i;
  end

  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      st_ff <= {`QBP_LATCH_RST, 8'h00, 8'h00};
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign rise_o = st_ff.rise;
  assign fall_o = st_ff.fall;
endmodule

// file: core/qbp_port.sv
/*
  Eight-pin quasi-bidirectional port with per-pin output latches, strong
  pulldown, momentary strong high driver, weak sustaining pullup and
  alternate functions. Assumes external pull resolution of the pin wire and
  asynchronous pin inputs.
*/
// Overview of operation
// - Eight pins, each I/O or alternate function
// - Reset sets all latches, weak pullups only
// - Latch one acts as input, read pin
// - Writing zero enables strong pulldown
// - Pulldown stays until one written or reset
// - Zero-to-one briefly enables strong high driver
// - Then weak sustaining pullup holds pin high
// - Bit 0 timer I/O, bit 1 trigger
// - Bit 2 serial receive, bit 3 transmit
// - Bit 4 rising-edge interrupt input
// - Bit 5 falling-edge interrupt input
// - Bit 6 rising-edge interrupt input
// - Bit 7 falling-edge interrupt input
`timescale 1ns/1ps
`include "qbp_consts.svh"

module qbp_port (
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  input wire logic wr_en_i,
  input wire qbp_pkg::qbp_byte_t wr_mask_i,
  input wire qbp_pkg::qbp_byte_t wr_data_i,
  input wire qbp_pkg::qbp_byte_t pin_i,
  input wire qbp_pkg::qbp_alt_out_s alt_out_i,
  output qbp_pkg::qbp_byte_t latch_o,
  output qbp_pkg::qbp_byte_t pin_level_o,
  output qbp_pkg::qbp_drive_s drive_o,
  output qbp_pkg::qbp_alt_in_s alt_in_o,
  output qbp_pkg::qbp_irq_s irq_o
);
  import qbp_pkg::*;

  localparam qbp_cnt_t STRONG_CYC = qbp_cnt_t'(`QBP_STRONG_CYC);

  typedef struct packed {
    qbp_byte_t latch;
    qbp_byte_t eff_prev;
    logic [`QBP_WIDTH-1:0][1:0] cnt;
    qbp_byte_t level;
    qbp_drive_s drive;
    qbp_alt_in_s alt_in;
    qbp_irq_s irq;
  } qbp_port_s;

  qbp_port_s st_ff;
  qbp_port_s nxt_st;
  qbp_byte_t sync_level;
  qbp_byte_t rise;
  qbp_byte_t fall;
  qbp_byte_t alt_val;
  qbp_byte_t eff;

  qbp_pin_sync u_sync (
    .clk_sys_i(clk_sys_i),
    .sys_rst_i(sys_rst_i),
    .pin_i(pin_i),
    .level_o(sync_level)
  );

  qbp_edge_det u_edge (
    .clk_sys_i(clk_sys_i),
    .sys_rst_i(sys_rst_i),
    .level_i(sync_level),
    .gate_i(st_ff.latch),
    .rise_o(rise),
    .fall_o(fall)
  );

  // Alternate output value per pin, one where no peripheral drives
  function automatic qbp_byte_t alt_mux(input qbp_alt_out_s a);
    qbp_byte_t v;
    v = `QBP_LATCH_RST;
    if (a.timer_two_ext_io_en) begin
      v[`QBP_BIT_T2_IO] = a.timer_two_ext_io;
    end
    if (a.second_serial_transmit_en) begin
      v[`QBP_BIT_SER_TX] = a.second_serial_transmit;
    end
    return v;
  endfunction

  always_comb begin
    alt_val = alt_mux(alt_out_i);
    nxt_st = st_ff;
    for (int i = 0; i < `QBP_WIDTH; i++) begin
      if (wr_en_i && wr_mask_i[i]) begin
        nxt_st.latch[i] = wr_data_i[i];
      end
    end
    eff = nxt_st.latch & alt_val;
    nxt_st.eff_prev = eff;
    for (int i = 0; i < `QBP_WIDTH; i++) begin
      if (!eff[i]) begin
        nxt_st.cnt[i] = 2'h0;
      end else if (!st_ff.eff_prev[i]) begin
        nxt_st.cnt[i] = STRONG_CYC;
      end else if (st_ff.cnt[i] != 2'h0) begin
        nxt_st.cnt[i] = st_ff.cnt[i] - 2'h1;
      end
      nxt_st.drive.pd_oe_n[i] = eff[i];
      nxt_st.drive.ph_oe_n[i] = (nxt_st.cnt[i] == 2'h0);
      nxt_st.drive.pu_weak[i] = eff[i];
    end
    nxt_st.level = sync_level;
    nxt_st.alt_in.timer_two_ext_io = sync_level[`QBP_BIT_T2_IO] & st_ff.latch[`QBP_BIT_T2_IO];
    nxt_st.alt_in.timer_two_capture_trigger =
      sync_level[`QBP_BIT_T2_TRIG] & st_ff.latch[`QBP_BIT_T2_TRIG];
    nxt_st.alt_in.second_serial_receive = sync_level[`QBP_BIT_SER_RX] & st_ff.latch[`QBP_BIT_SER_RX];
    nxt_st.irq.ext_irq_rise_a = rise[`QBP_BIT_IRQ_RA];
    nxt_st.irq.ext_irq_fall_a = fall[`QBP_BIT_IRQ_FA];
    nxt_st.irq.ext_irq_rise_b = rise[`QBP_BIT_IRQ_RB];
    nxt_st.irq.ext_irq_fall_b = fall[`QBP_BIT_IRQ_FB];
  end

  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      st_ff <= '0;
      st_ff.latch <= `QBP_LATCH_RST;
      st_ff.eff_prev <= `QBP_LATCH_RST;
      st_ff.level <= `QBP_LATCH_RST;
      st_ff.drive.pd_oe_n <= `QBP_LATCH_RST;
      st_ff.drive.ph_oe_n <= `QBP_LATCH_RST;
      st_ff.drive.pu_weak <= `QBP_LATCH_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign latch_o = st_ff.latch;
  assign pin_level_o = st_ff.level;
  assign drive_o = st_ff.drive;
  assign alt_in_o = st_ff.alt_in;
  assign irq_o = st_ff.irq;
endmodule

// file: verification/qbp_port_properties.sv
/* Checker on qbp_port ports. Assumes one clock, async high reset. */
`timescale 1ns/1ps
module qbp_port_chk import qbp_pkg::*; (
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  input wire logic wr_en_i,
  input wire qbp_byte_t wr_mask_i,
  input wire qbp_byte_t wr_data_i,
  input wire qbp_byte_t latch_o,
  input wire qbp_byte_t pin_level_o,
  input wire qbp_drive_s drive_o,
  input wire qbp_alt_in_s alt_in_o,
  input wire qbp_irq_s irq_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (sys_rst_i);
  sequence s_up(int k);
    !drive_o.pd_oe_n[k] ##1 drive_o.pd_oe_n[k];
  endsequence
  // A zero written in the first pulse cycle legally cuts the pulse short
  property p_pulse(int k);
    s_up(k) ##0 !(wr_en_i && wr_mask_i[k] && !wr_data_i[k]) |->
      !drive_o.ph_oe_n[k] [*2] ##1 drive_o.ph_oe_n[k];
  endproperty
  a_reset_ones: assert property ($fell(sys_rst_i) |-> latch_o == 8'hFF && drive_o.pu_weak == 8'hFF)
    else $error("not ones after reset");
  a_latch_write: assert property (wr_en_i |=> latch_o == ($past(latch_o) & ~$past(wr_mask_i)
    | $past(wr_data_i) & $past(wr_mask_i))) else $error("bad latch write");
  a_latch_hold: assert property (!wr_en_i |=> $stable(latch_o)) else $error("latch moved");
  a_pull_down: assert property (drive_o.pd_oe_n[7:4] == latch_o[7:4]
    && drive_o.pd_oe_n[2:1] == latch_o[2:1]) else $error("pulldown wrong");
  a_weak_pull: assert property (drive_o.pu_weak == drive_o.pd_oe_n) else $error("weak pull wrong");
  a_high_pulse: assert property (p_pulse(2)) else $error("pulse wrong");
  a_pulse_cause: assert property ($fell(drive_o.ph_oe_n[5]) |-> $rose(drive_o.pd_oe_n[5]))
    else $error("stray pulse");
  a_irq_rise: assert property ($rose(pin_level_o[4]) && latch_o[4] |->
    ##[1:2] (irq_o.ext_irq_rise_a || !latch_o[4])) else $error("no rise irq");
  a_irq_once: assert property (irq_o.ext_irq_fall_b |=> !irq_o.ext_irq_fall_b) else $error("long irq");
  a_alt_gate: assert property (!latch_o[1] [*2] |-> !alt_in_o.timer_two_capture_trigger)
    else $error("alt not gated");
endmodule
bind qbp_port qbp_port_chk u_chk (.clk_sys_i, .sys_rst_i, .wr_en_i, .wr_mask_i, .wr_data_i,
  .latch_o, .pin_level_o, .drive_o, .alt_in_o, .irq_o);

// file: verification/qbp_pins_model.sv
/* Outside circuit on the pins. Assumes active-low strong enables. */
`timescale 1ns/1ps
module qbp_pins_model import qbp_pkg::*; #(parameter int DLY_NS = 0) (
  input wire qbp_drive_s drive_i,
  input wire qbp_byte_t ext_low_i,
  output qbp_byte_t pin_o
);
  // Pulldown, then strong high, then outside low, else pullup
  assign #(DLY_NS) pin_o = drive_i.pd_oe_n & (~drive_i.ph_oe_n | ~ext_low_i);
endmodule

// file: verification/quasi_bidir_port_one_tb.sv
/* Bench for qbp_port with pin model. Assumes 10 MHz clock. */
`timescale 1ns/1ps
module quasi_bidir_port_one_tb;
  import qbp_pkg::*;
  logic clk_sys_i = 0, sys_rst_i = 1, wr_en_i = 0;
  qbp_byte_t wr_mask_i = 0, wr_data_i = 0, pin_i, latch_o, pin_level_o, ext_low = 0, old;
  qbp_alt_out_s alt_out_i = 0;
  qbp_drive_s drive_o;
  qbp_alt_in_s alt_in_o;
  qbp_irq_s irq_o;
  int errors = 0, samples_checked = 0, cyc = 0, m_latch = 255, n_irq[4];
  logic [31:0] seed = 32'hFC18878B, r;
  qbp_port u_dut (.clk_sys_i, .sys_rst_i, .wr_en_i, .wr_mask_i, .wr_data_i, .pin_i, .alt_out_i,
    .latch_o, .pin_level_o, .drive_o, .alt_in_o, .irq_o);
  qbp_pins_model #(.DLY_NS(30)) u_pins (.drive_i(drive_o), .ext_low_i(ext_low), .pin_o(pin_i));
  initial forever #50 clk_sys_i = ~clk_sys_i;
  always @(posedge clk_sys_i) begin
    cyc++;
    foreach (n_irq[i]) n_irq[i] += int'(irq_o[3-i]);
    if (cyc == 3000) begin
      errors++;
      wrap_up();
    end
  end
  task automatic chk(string what, logic [7:0] seen, logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED %s exp %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(logic [7:0] m, logic [7:0] d);
    @(negedge clk_sys_i);
    wr_en_i = 1;
    wr_mask_i = m;
    wr_data_i = d;
    m_latch = m_latch & ~m | d & m;
    @(negedge clk_sys_i);
    wr_en_i = 0;
  endtask
  task automatic wait_n(int n);
    repeat (n) @(negedge clk_sys_i);
  endtask
  function automatic logic [31:0] xorshift(logic [31:0] s);
    logic [31:0] x;
    x = s;
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction
  task automatic wrap_up();
    $display("checked %0d errors %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial begin
    wait_n(16);
    sys_rst_i = 0;
    chk("latch", latch_o, 8'hFF);
    chk("strong", drive_o.pd_oe_n & drive_o.ph_oe_n & drive_o.pu_weak, 8'hFF);
    $display("reset test done");
    for (int i = 0; i < 24; i++) begin
      old = m_latch[7:0];
      seed = xorshift(seed);
      r = seed;
      wr(r[7:0], r[15:8]);
      chk("latch", latch_o, m_latch[7:0]);
      chk("pulldown", drive_o.pd_oe_n, m_latch[7:0]);
      chk("pulse", ~drive_o.ph_oe_n, m_latch[7:0] & ~old);
      wait_n(6);
      chk("pin", pin_level_o, m_latch[7:0]);
      chk("settled", drive_o.ph_oe_n, 8'hFF);
      chk("weak", drive_o.pu_weak, m_latch[7:0]);
      chk("alt in", 8'(alt_in_o), {5'h00, m_latch[0], m_latch[1], m_latch[2]});
    end
    $display("write test done");
    wr(8'hFF, 8'hFF);
    wait_n(8);
    n_irq = '{default: 0};
    ext_low = 8'hF7;
    wait_n(8);
    chk("low", pin_level_o, 8'h08);
    chk("alt", 8'(alt_in_o), 8'h00);
    ext_low = 0;
    wait_n(8);
    chk("alt", 8'(alt_in_o), 8'h07);
    foreach (n_irq[i]) chk("irq", 8'(n_irq[i]), 8'h01);
    n_irq = '{default: 0};
    wr(8'hF0, 8'h00);
    wait_n(8);
    foreach (n_irq[i]) chk("gated", 8'(n_irq[i]), 8'h00);
    sys_rst_i = 1;
    wait_n(2);
    sys_rst_i = 0;
    m_latch = 255;
    chk("rst latch", latch_o, 8'hFF);
    chk("rst drive", drive_o.pd_oe_n & drive_o.ph_oe_n & drive_o.pu_weak, 8'hFF);
    $display("input test done");
    wr(8'hFF, 8'hFF);
    wait_n(4);
    alt_out_i = 4'hA;
    wait_n(3);
    chk("alt out", drive_o.pd_oe_n, 8'hF6);
    alt_out_i = 4'hF;
    wait_n(1);
    chk("alt pulse", ~drive_o.ph_oe_n, 8'h09);
    wait_n(3);
    chk("alt out", drive_o.pd_oe_n & drive_o.ph_oe_n, 8'hFF);
    $display("alt test done");
    wrap_up();
  end
endmodule
